// ---- design/timer16_pkg.sv ----
// package for the 16-bit capture/reload timer: register map, field positions, reset values, timing
// assumes a single 10 MHz clock domain and an Avalon-MM slave with 32-bit data
package timer16_pkg;

  // register byte addresses, one aligned word each
  localparam logic [4:0] ADDR_CONTROL   = 5'h00;  // control_register
  localparam logic [4:0] ADDR_MODE      = 5'h04;  // mode_register (down count enable, twelve clock)
  localparam logic [4:0] ADDR_COUNT     = 5'h08;  // count_high:count_low
  localparam logic [4:0] ADDR_RELOAD    = 5'h0C;  // reload_capture_high:reload_capture_low
  localparam logic [4:0] ADDR_IRQ_STAT  = 5'h10;  // sticky event status, write one to clear
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h14;  // interrupt mask, same layout as status

  // control register field positions, msb to lsb
  localparam int CTL_OVF  = 7;  // overflow_flag
  localparam int CTL_EXT  = 6;  // external_event_flag
  localparam int CTL_RXB  = 5;  // rx_baud_select
  localparam int CTL_TXB  = 4;  // tx_baud_select
  localparam int CTL_TEN  = 3;  // external_trigger_enable
  localparam int CTL_RUN  = 2;  // run_control
  localparam int CTL_SRC  = 1;  // count_source_select
  localparam int CTL_CAP  = 0;  // capture_reload_select

  // mode register field positions
  localparam int MOD_DOWN_COUNT_ENABLE = 0;  // down_count_enable
  localparam int MOD_TWLV = 1;  // twelve clock machine cycle

  // interrupt status / mask positions
  localparam int IRQ_OVF  = 0;  // overflow event
  localparam int IRQ_EXT  = 1;  // trigger pin event
  localparam int IRQ_BAUD = 2;  // baud overflow pulse event

  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [2:0]  IRQ_RST     = 3'h0;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

  // timing: machine cycle is 6 (or 12) oscillator periods; the 10 MHz clock is the oscillator
  localparam int CLOCK_NS        = 100;   // clock period in ns
  localparam int OSC_PER_MC6     = 6;     // oscillator periods per machine cycle, six clock mode
  localparam int OSC_PER_MC12    = 12;    // twelve clock mode
  localparam int OSC_PER_STATE6  = 1;     // baud generator tick, six clock mode (osc)
  localparam int OSC_PER_STATE12 = 2;     // baud generator tick, twelve clock mode (osc/2)
  localparam logic [3:0] MC_DIV6   = 4'(OSC_PER_MC6 - 1);
  localparam logic [3:0] MC_DIV12  = 4'(OSC_PER_MC12 - 1);
  localparam logic [3:0] ST_DIV6   = 4'(OSC_PER_STATE6 - 1);
  localparam logic [3:0] ST_DIV12  = 4'(OSC_PER_STATE12 - 1);

endpackage

// ---- design/capture_reload_timer16.sv ----
// 16-bit timer/counter with capture, up/down auto-reload and baud clock source modes
// assumes one 10 MHz clock, async active-low reset, Avalon-MM slave, pins synchronous to CLOCK
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
module capture_reload_timer16
  import timer16_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // avalon-mm slave
  input  wire logic [4:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  // pins
  input  wire logic        TRIGGER_PIN,
  input  wire logic        COUNT_PIN,
  input  wire logic        AUX_TIMER_OVERFLOW,
  // serial clock pulses and interrupts
  output logic             RX_BAUD_PULSE,
  output logic             TX_BAUD_PULSE,
  output logic             TIMER_IRQ,
  output logic             IRQ
);

  // arithmetic used by up and down stepping
  function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
    step16 = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction

  // ------------------------------------------------------------------ registers
  logic [7:0]  control_reg;     // control register
  logic [7:0]  control_next;
  logic [1:0]  mode_reg;        // down count enable, twelve clock
  logic [15:0] count_reg;       // count_high:count_low
  logic [15:0] count_next;
  logic [15:0] reload_reg;      // reload_capture_high:reload_capture_low
  logic [15:0] reload_next;
  logic [2:0]  irq_stat_reg;    // sticky events
  logic [2:0]  irq_stat_next;
  logic [2:0]  irq_mask_reg;    // event mask
  logic [3:0]  div_reg;         // machine cycle / state divider
  logic        ack_reg;         // one wait cycle then answer
  logic [31:0] rdata_reg;
  logic        trig_s1_reg;     // synchroniser stage one
  logic        trig_s2_reg;     // synchroniser stage two
  logic        trig_smp_reg;    // machine cycle sample
  logic        cnt_s1_reg;
  logic        cnt_s2_reg;
  logic        cnt_smp_reg;
  logic        rx_pulse_reg;
  logic        tx_pulse_reg;
  logic        timer_irq_reg;
  logic        irq_reg;

  // ------------------------------------------------------------------ decode
  wire         bus_hit   = (READ | WRITE) & ~ack_reg;     // first cycle of a request
  wire         wr_take   = WRITE & ack_reg;               // write lands at the answering edge
  wire         wr_ctl    = wr_take & (ADDRESS == ADDR_CONTROL) & BYTEENABLE[0];
  wire         wr_mode   = wr_take & (ADDRESS == ADDR_MODE) & BYTEENABLE[0];
  wire         wr_cnt_lo = wr_take & (ADDRESS == ADDR_COUNT) & BYTEENABLE[0];
  wire         wr_cnt_hi = wr_take & (ADDRESS == ADDR_COUNT) & BYTEENABLE[1];
  wire         wr_rel_lo = wr_take & (ADDRESS == ADDR_RELOAD) & BYTEENABLE[0];
  wire         wr_rel_hi = wr_take & (ADDRESS == ADDR_RELOAD) & BYTEENABLE[1];
  wire         wr_stat   = wr_take & (ADDRESS == ADDR_IRQ_STAT) & BYTEENABLE[0];
  wire         wr_mask   = wr_take & (ADDRESS == ADDR_IRQ_MASK) & BYTEENABLE[0];

  // control fields
  wire         rx_sel    = control_reg[CTL_RXB];
  wire         tx_sel    = control_reg[CTL_TXB];
  wire         baud_mode = rx_sel | tx_sel;
  wire         trig_en   = control_reg[CTL_TEN];
  wire         run       = control_reg[CTL_RUN];
  wire         src_pin   = control_reg[CTL_SRC];
  wire         capture   = control_reg[CTL_CAP] & ~baud_mode;
  wire         down_count_enable      = mode_reg[MOD_DOWN_COUNT_ENABLE];
  wire         twelve    = mode_reg[MOD_TWLV];

  // ------------------------------------------------------------------ tick generation
  // baud mode runs the timer at the state rate, otherwise once per machine cycle
  wire [3:0]   div_top   = baud_mode ? (twelve ? ST_DIV12 : ST_DIV6)
                                     : (twelve ? MC_DIV12 : MC_DIV6);
  wire         mc_tick   = (div_reg >= div_top);
  // machine cycle sampling of pins; the second synchroniser flop feeds everything
  wire         trig_fall = mc_tick & trig_smp_reg & ~trig_s2_reg;
  wire         cnt_fall  = mc_tick & cnt_smp_reg & ~cnt_s2_reg;
  // the count source selects machine cycles or pin falls
  wire         tick      = run & (src_pin ? cnt_fall : mc_tick);

  // direction: pin high counts up when down counting enabled, never in capture or baud
  wire         down_ok   = down_count_enable & ~capture & ~baud_mode;
  wire         count_up  = ~down_ok | trig_s2_reg;
  // overflow when counting up past FFFF; underflow when the count meets the reload value
  wire         ovf_up    = tick & count_up & (count_reg == COUNT_MAX);
  wire         unf_down  = tick & ~count_up & (count_reg == reload_reg);
  wire         roll      = ovf_up | unf_down;
  // trigger events are honoured only when enabled
  wire         trig_evt  = trig_en & trig_fall;
  wire         trig_act  = trig_evt & ~baud_mode & ~down_ok;
  wire         do_cap    = trig_act & capture;
  wire         do_rel    = trig_act & ~capture;

  // ------------------------------------------------------------------ next state
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      count_next = step16(count_reg, count_up);
    end
    if (ovf_up & ~capture) begin
      count_next = reload_reg;
    end
    if (unf_down) begin
      count_next = COUNT_MAX;
    end
    if (do_rel) begin
      count_next = reload_reg;
    end
    if (wr_cnt_lo) begin
      count_next[7:0] = WRITEDATA[7:0];
    end
    if (wr_cnt_hi) begin
      count_next[15:8] = WRITEDATA[15:8];
    end
  end

  // capture takes the count as it stands before this cycle's step
  always_comb begin
    reload_next = reload_reg;
    if (wr_rel_lo) begin
      reload_next[7:0] = WRITEDATA[7:0];
    end
    if (wr_rel_hi) begin
      reload_next[15:8] = WRITEDATA[15:8];
    end
    if (do_cap) begin
      reload_next = count_reg;
    end
  end

  // flags: software write stores, hardware set wins over a same-cycle clear
  always_comb begin
    control_next = control_reg;
    if (wr_ctl) begin
      control_next = WRITEDATA[7:0];
    end
    if (roll & ~baud_mode) begin
      control_next[CTL_OVF] = 1'b1;
    end
    if (down_ok & roll) begin
      control_next[CTL_EXT] = ~control_reg[CTL_EXT];
    end else if (trig_evt & ~down_ok) begin
      control_next[CTL_EXT] = 1'b1;
    end
  end

  // sticky interrupt status; the toggling event flag of down mode raises nothing
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~WRITEDATA[2:0];
    end
    if (roll & ~baud_mode) begin
      irq_stat_next[IRQ_OVF] = 1'b1;
    end
    if (trig_evt & ~down_ok) begin
      irq_stat_next[IRQ_EXT] = 1'b1;
    end
    if (roll & baud_mode) begin
      irq_stat_next[IRQ_BAUD] = 1'b1;
    end
  end

  // read multiplexer, unmapped addresses read zero
  logic [31:0] rdata_mux;
  always_comb begin
    unique case (ADDRESS)
      ADDR_CONTROL:  rdata_mux = {24'h00_0000, control_reg};
      ADDR_MODE:     rdata_mux = {30'h0000_0000, mode_reg};
      ADDR_COUNT:    rdata_mux = {16'h0000, count_reg};
      ADDR_RELOAD:   rdata_mux = {16'h0000, reload_reg};
      ADDR_IRQ_STAT: rdata_mux = {29'h0000_0000, irq_stat_reg};
      ADDR_IRQ_MASK: rdata_mux = {29'h0000_0000, irq_mask_reg};
      default:       rdata_mux = 32'h0000_0000;
    endcase
  end

  // timer interrupt follows either software-visible flag, except toggling in down mode
  wire timer_irq_next = control_next[CTL_OVF] | (control_next[CTL_EXT] & ~down_ok);
  wire irq_next       = |(irq_stat_next & irq_mask_reg);

  // ------------------------------------------------------------------ bus handshake
  // every access answers on the second edge: waitrequest high in the first cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_hit;
      rdata_reg <= bus_hit ? rdata_mux : rdata_reg;
    end
  end

  // machine cycle divider
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= mc_tick ? 4'h0 : 4'(div_reg + 4'h1);
    end
  end

  // pin synchronisers and once-per-machine-cycle samples
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      trig_s1_reg  <= 1'b1;
      trig_s2_reg  <= 1'b1;
      trig_smp_reg <= 1'b1;
      cnt_s1_reg   <= 1'b1;
      cnt_s2_reg   <= 1'b1;
      cnt_smp_reg  <= 1'b1;
    end else begin
      trig_s1_reg  <= TRIGGER_PIN;
      trig_s2_reg  <= trig_s1_reg;
      cnt_s1_reg   <= COUNT_PIN;
      cnt_s2_reg   <= cnt_s1_reg;
      if (mc_tick) begin
        trig_smp_reg <= trig_s2_reg;
        cnt_smp_reg  <= cnt_s2_reg;
      end
    end
  end

  // timer state
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      control_reg  <= CONTROL_RST;
      mode_reg     <= MODE_RST;
      count_reg    <= COUNT_RST;
      reload_reg   <= RELOAD_RST;
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
    end else begin
      control_reg  <= control_next;
      mode_reg     <= wr_mode ? WRITEDATA[1:0] : mode_reg;
      count_reg    <= count_next;
      reload_reg   <= reload_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= wr_mask ? WRITEDATA[2:0] : irq_mask_reg;
    end
  end

  // registered outputs: baud pulses, interrupt levels
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_pulse_reg  <= 1'b0;
      tx_pulse_reg  <= 1'b0;
      timer_irq_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      rx_pulse_reg  <= rx_sel ? roll : AUX_TIMER_OVERFLOW;
      tx_pulse_reg  <= tx_sel ? roll : AUX_TIMER_OVERFLOW;
      timer_irq_reg <= timer_irq_next;
      irq_reg       <= irq_next;
    end
  end

  assign READDATA      = rdata_reg;
  assign WAITREQUEST   = ~ack_reg;
  assign RX_BAUD_PULSE = rx_pulse_reg;
  assign TX_BAUD_PULSE = tx_pulse_reg;
  assign TIMER_IRQ     = timer_irq_reg;
  assign IRQ           = irq_reg;

endmodule

// ---- verif/pin_model.sv ----
// far-side model: trigger pin, count pin and the auxiliary timer overflow
// assumes the bench calls its tasks; levels change just after a rising edge
`timescale 1ns/1ns
module pin_model (
  input  wire logic CLOCK,
  output logic      TRIGGER_PIN,
  output logic      COUNT_PIN,
  output logic      AUX_TIMER_OVERFLOW
);
  localparam int HOLD = 20;  // over one twelve clock machine cycle, so a slow sampler still sees each level

  // idle levels: both pins high, no pulse
  initial begin
    TRIGGER_PIN        = 1'b1;
    COUNT_PIN          = 1'b1;
    AUX_TIMER_OVERFLOW = 1'b0;
  end

  // new trigger level, held until it must have been sampled
  task automatic trig_set(input logic v);
    @(posedge CLOCK);
    TRIGGER_PIN <= v;
    repeat (HOLD) @(posedge CLOCK);
  endtask

  // n falling edges on the count pin, each level held
  task automatic count_falls(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      COUNT_PIN <= 1'b0;
      repeat (HOLD) @(posedge CLOCK);
      COUNT_PIN <= 1'b1;
      repeat (HOLD) @(posedge CLOCK);
    end
  endtask

  // one-cycle overflow pulse from the auxiliary timer
  task automatic aux_pulse;
    @(posedge CLOCK);
    AUX_TIMER_OVERFLOW <= 1'b1;
    @(posedge CLOCK);
    AUX_TIMER_OVERFLOW <= 1'b0;
  endtask
endmodule

// ---- verif/timer16_properties.sv ----
// checker: bus handshake, register readback and baud pulse routing
// assumes it is bound to the timer and sees its ports only
`timescale 1ns/1ns
module timer16_checker
  import timer16_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic [4:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0]  BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic        AUX_TIMER_OVERFLOW,
  input wire logic        RX_BAUD_PULSE,
  input wire logic        TX_BAUD_PULSE,
  input wire logic        IRQ
);
  logic [5:0] ctl_sh;                                       // software-only control bits
  logic [1:0] mode_sh;                                      // last mode written
  logic [2:0] mask_sh;                                      // last mask written
  wire        wr_ok = WRITE && !WAITREQUEST && BYTEENABLE[0];  // low lane lands now
  wire        rd_ok = READ && !WAITREQUEST;                    // read data taken now
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  // shadows: hardware never changes these fields, so they must read back as written
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_sh  <= '0;
      mode_sh <= '0;
      mask_sh <= '0;
    end else if (wr_ok) begin
      if (ADDRESS == ADDR_CONTROL) ctl_sh <= WRITEDATA[5:0];
      if (ADDRESS == ADDR_MODE) mode_sh <= WRITEDATA[1:0];
      if (ADDRESS == ADDR_IRQ_MASK) mask_sh <= WRITEDATA[2:0];
    end
  end

  property p_wait_one; !WAITREQUEST |=> WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer lasted over one cycle");
  property p_wait_answer; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered next cycle");
  property p_unmapped; rd_ok && ADDRESS > ADDR_IRQ_MASK |-> READDATA == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_read; rd_ok && ADDRESS == ADDR_CONTROL |-> READDATA[31:8] == 24'h00_0000 && READDATA[5:0] == ctl_sh; endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  property p_mode_read; rd_ok && ADDRESS == ADDR_MODE |-> READDATA == {30'h0000_0000, mode_sh}; endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
  property p_mask_read; rd_ok && ADDRESS == ADDR_IRQ_MASK |-> READDATA == {29'h0000_0000, mask_sh}; endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
  property p_irq_masked; mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !IRQ; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");
  property p_rx_aux; !ctl_sh[CTL_RXB] |=> RX_BAUD_PULSE == $past(AUX_TIMER_OVERFLOW); endproperty
  a_rx_aux: assert property (p_rx_aux) else $error("receive pulse not from aux timer");
  property p_tx_aux; !ctl_sh[CTL_TXB] |=> TX_BAUD_PULSE == $past(AUX_TIMER_OVERFLOW); endproperty
  a_tx_aux: assert property (p_tx_aux) else $error("transmit pulse not from aux timer");
endmodule

bind capture_reload_timer16 timer16_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .ADDRESS(ADDRESS),
  .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .AUX_TIMER_OVERFLOW(AUX_TIMER_OVERFLOW), .RX_BAUD_PULSE(RX_BAUD_PULSE),
  .TX_BAUD_PULSE(TX_BAUD_PULSE), .IRQ(IRQ));

// ---- verif/testbench.sv ----
// self-checking bench: avalon-mm register tasks and one scenario per timer mode
// assumes the pin model drives the trigger, count and auxiliary overflow pins
`timescale 1ns/1ns
module testbench;
  import timer16_pkg::*;
  logic        clock, rstn, read, write;
  logic [4:0]  address;
  logic [3:0]  be;
  logic [31:0] writedata, rd, keep;
  wire  [31:0] readdata;
  wire         waitrequest, trig, cnt, aux, rx_p, tx_p, tirq, irq;
  int          bad_count, check_count, rx_n, tx_n;

  capture_reload_timer16 u_dut (.CLOCK(clock), .RSTN(rstn), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(be), .READDATA(readdata), .WAITREQUEST(waitrequest),
    .TRIGGER_PIN(trig), .COUNT_PIN(cnt), .AUX_TIMER_OVERFLOW(aux), .RX_BAUD_PULSE(rx_p),
    .TX_BAUD_PULSE(tx_p), .TIMER_IRQ(tirq), .IRQ(irq));
  pin_model u_pins (.CLOCK(clock), .TRIGGER_PIN(trig), .COUNT_PIN(cnt), .AUX_TIMER_OVERFLOW(aux));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // baud pulses counted mid-cycle, where they are settled
  always @(negedge clock) begin
    rx_n += (rx_p === 1'b1);
    tx_n += (tx_p === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one bus cycle; waitrequest is taken at each rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 20) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd & m);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0000_0000; be = 4'hF;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rdchk("reset value", 5'(a), 32'hFFFF_FFFF, 32'h0000_0000);
    u_pins.aux_pulse();
    repeat (3) @(posedge clock);
    chk("aux routed", 32'h0000_0002, 32'(rx_n + tx_n));
    // up count through 0xFFFF: overflow flag, reload to 0xFFF0
    bus(1'b1, ADDR_RELOAD, 32'h0000_FFF0);
    bus(1'b1, ADDR_COUNT, 32'h0000_FFFE);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0004);
    repeat (40) @(posedge clock);
    rdchk("reloaded", ADDR_COUNT, 32'h0000_FFF8, 32'h0000_FFF0);
    rdchk("overflow flag", ADDR_CONTROL, 32'h0000_00C0, 32'h0000_0080);
    rdchk("status", ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0080);
    chk("timer irq", 32'h0000_0001, 32'(tirq));
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(negedge clock);
    chk("irq", 32'h0000_0001, 32'(irq));
    bus(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
    @(negedge clock);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    @(negedge clock);
    chk("timer irq off", 32'h0000_0000, 32'(tirq));
    // capture mode: ignored fall, then a capture that does not disturb the count
    bus(1'b1, ADDR_COUNT, 32'h0000_1234);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0005);
    u_pins.trig_set(1'b0);
    u_pins.trig_set(1'b1);
    rdchk("ignored fall", ADDR_CONTROL, 32'h0000_0040, 32'h0000_0000);
    rdchk("no capture", ADDR_RELOAD, 32'h0000_FFFF, 32'h0000_FFF0);
    bus(1'b1, ADDR_CONTROL, 32'h0000_000D);
    u_pins.trig_set(1'b0);
    rdchk("event flag", ADDR_CONTROL, 32'h0000_00C0, 32'h0000_0040);
    rdchk("captured", ADDR_RELOAD, 32'h0000_FF00, 32'h0000_1200);
    keep = rd;
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    bus(1'b0, ADDR_COUNT, 32'h0000_0000);
    chk("count ran on", 32'h0000_0001, 32'(rd > keep));
    keep = rd;
    repeat (30) @(posedge clock);
    rdchk("count held", ADDR_COUNT, 32'h0000_FFFF, keep);
    u_pins.trig_set(1'b1);
    // external count pin: exactly five falls
    bus(1'b1, ADDR_COUNT, 32'h0000_0000);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0006);
    u_pins.count_falls(5);
    rdchk("pin count", ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0005);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    // low byte lane only: the high count byte must keep its value
    be <= 4'h1;
    bus(1'b1, ADDR_COUNT, 32'h0000_ABCD);
    be <= 4'hF;
    rdchk("low lane only", ADDR_COUNT, 32'h0000_FFFF, 32'h0000_00CD);
    // down count to the reload value, then 0xFFFF and a toggled event flag
    bus(1'b1, ADDR_MODE, 32'h0000_0001);
    bus(1'b1, ADDR_RELOAD, 32'h0000_0100);
    bus(1'b1, ADDR_COUNT, 32'h0000_0103);
    u_pins.trig_set(1'b0);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0004);
    repeat (50) @(posedge clock);
    rdchk("underflow", ADDR_COUNT, 32'h0000_FF00, 32'h0000_FF00);
    rdchk("down flags", ADDR_CONTROL, 32'h0000_00C0, 32'h0000_00C0);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    bus(1'b1, ADDR_MODE, 32'h0000_0000);
    u_pins.trig_set(1'b1);
    // baud mode: rollover every 16 clocks, capture select ignored, no overflow flag
    bus(1'b1, ADDR_RELOAD, 32'h0000_FFF0);
    bus(1'b1, ADDR_COUNT, 32'h0000_FFF0);
    rx_n = 0;
    tx_n = 0;
    bus(1'b1, ADDR_CONTROL, 32'h0000_0035);
    repeat (160) @(posedge clock);
    bus(1'b1, ADDR_CONTROL, 32'h0000_0030);
    chk("rx pulses", 32'h0000_0001, 32'(rx_n inside {[8:13]}));
    chk("tx pulses", 32'h0000_0001, 32'(tx_n inside {[8:13]}));
    rdchk("baud no flag", ADDR_CONTROL, 32'h0000_0080, 32'h0000_0000);
    test_done();
  end
endmodule
